// file: hw/ddr_cmd_pkg.sv
/*
 * Constants for the module-side command, clock-enable and data-lane logic.
 * Assumes one system clock that runs well above the memory clock pair.
 */
package ddr_cmd_pkg;

  localparam int ADDR_PINS   = 13;
  localparam int BANKS       = 4;
  localparam int LANES       = 8;
  localparam int DQ_W        = 64;
  localparam int A10_POS     = 10;
  localparam int ROW_BITS_LG = 13;
  localparam int ROW_BITS_SM = 12;

  // Command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_LMR     = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRE     = 3'h2;
  localparam logic [2:0] CMD_ACT     = 3'h3;
  localparam logic [2:0] CMD_WRITE   = 3'h4;
  localparam logic [2:0] CMD_READ    = 3'h5;
  localparam logic [2:0] CMD_BST     = 3'h6;
  localparam logic [2:0] CMD_NOP     = 3'h7;

  localparam logic [1:0] BA_MODE     = 2'h0;
  localparam logic [1:0] BA_EXT_MODE = 2'h1;

  localparam logic [12:0] MODE_RST = 13'h0000;
  localparam logic [7:0]  STROBE_HI = 8'hff;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_PD_PRE,
    PWR_PD_ACT,
    PWR_SELF_REF
  } pwr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT,
    RD_FIRST,
    RD_SECOND
  } rd_state_t;

endpackage

// file: hw/mem_port_if.sv
/*
 * Carrier between the command logic and its storage array.
 * Assumes both ends sit on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface mem_port_if #(
  parameter int AW = 4,
  parameter int DW = 128
);
  logic            we;
  logic [DW/8-1:0] be;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wdata;
  logic            re;
  logic [DW-1:0]   rdata;

  modport ctrl (output we, be, addr, wdata, re, input rdata);
  modport mem  (input we, be, addr, wdata, re, output rdata);
endinterface

`default_nettype wire

// file: hw/lane_mem.sv
/*
 * Small byte-writable array holding double-width data words.
 * Assumes one access per cycle; read data appear one cycle after re.
 */
`timescale 1ns/1ps
`default_nettype none

module lane_mem #(
  parameter int AW = 4,
  parameter int DW = 128
) (
  input  wire logic clk_sys,
  mem_port_if.mem   mp
);

  logic [DW-1:0] store [2**AW];

  // Byte enables only make sense for whole bytes
  if (DW % 8 != 0 || AW < 1) begin : g_bad_width
    $error("DW must be a multiple of 8 and AW at least 1");
  end

  always_ff @(posedge clk_sys) begin
    if (mp.we) begin
      for (int i = 0; i < DW/8; i++) begin
        if (mp.be[i]) begin
          store[mp.addr][8*i +: 8] <= mp.wdata[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mp.re) begin
      mp.rdata <= store[mp.addr];
    end
  end

endmodule // lane_mem

`default_nettype wire

// file: hw/ddr_module_cmd.sv
/*
 * Module-side command decoder, power-state control and byte-lane data path.
 * Assumes clk_sys runs several times faster than the memory clock pair and
 * that the pins arrive asynchronously; all pins pass two flip-flops first.
 */
`timescale 1ns/1ps
`default_nettype none

module ddr_module_cmd
  import ddr_cmd_pkg::*;
#(
  parameter int ROW_BITS = ROW_BITS_LG,
  parameter int COL_W    = 2
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 ck,
  input  wire logic                 ck_n,
  input  wire logic                 rank_clock_enable,
  input  wire logic                 rank_select_n,
  input  wire logic                 ras_n,
  input  wire logic                 cas_n,
  input  wire logic                 we_n,
  input  wire logic [1:0]           ba,
  input  wire logic [ADDR_PINS-1:0] addr,
  input  wire logic [LANES-1:0]     dm,
  input  wire logic [DQ_W-1:0]      dq_i,
  output logic      [DQ_W-1:0]      dq_o,
  output logic                      dq_oe,
  input  wire logic [LANES-1:0]     dqs_i,
  output logic      [LANES-1:0]     dqs_o,
  output logic      [LANES-1:0]     dqs_oe,
  output pwr_state_t                pwr_state_q,
  output logic      [BANKS-1:0]     bank_open_q,
  output logic      [ADDR_PINS-1:0] last_row_q,
  output logic      [ADDR_PINS-1:0] mode_reg_q,
  output logic      [ADDR_PINS-1:0] ext_mode_reg_q
);

  if (ROW_BITS != ROW_BITS_LG && ROW_BITS != ROW_BITS_SM) begin : g_bad_rows
    $error("ROW_BITS must be 12 or 13");
  end
  if (COL_W < 1 || COL_W > 10) begin : g_bad_cols
    $error("COL_W must be 1 to 10");
  end

  localparam int AW = 2 + COL_W;
  // top pin unconnected on the small variant
  localparam logic [ADDR_PINS-1:0] ROW_MASK = ADDR_PINS'((1 << ROW_BITS) - 1);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SW = 2 + 1 + 1 + 3 + 2 + ADDR_PINS;
  logic [SW-1:0]       ctl_s1, ctl_s2;
  logic [LANES-1:0]    dm_s1, dm_s2, dqs_s1, dqs_s2, dqs_s3;
  logic [DQ_W-1:0]     dq_s1, dq_s2;
  logic                ckd_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctl_s1 <= '0;
      ctl_s2 <= '0;
    end else begin
      ctl_s1 <= {ck, ck_n, rank_clock_enable, rank_select_n,
                 ras_n, cas_n, we_n, ba, addr};
      ctl_s2 <= ctl_s1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dm_s1  <= '0;
      dm_s2  <= '0;
      dq_s1  <= '0;
      dq_s2  <= '0;
      dqs_s1 <= '0;
      dqs_s2 <= '0;
      dqs_s3 <= '0;
    end else begin
      dm_s1  <= dm;
      dm_s2  <= dm_s1;
      dq_s1  <= dq_i;
      dq_s2  <= dq_s1;
      dqs_s1 <= dqs_i;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
    end
  end

  logic                 ck_s, ckn_s, cke_s, cs_n_s, ckd, ck_rise, ck_fall;
  logic [2:0]           cmd_s;
  logic [1:0]           ba_s;
  logic [ADDR_PINS-1:0] addr_s;
  assign {ck_s, ckn_s, cke_s, cs_n_s, cmd_s, ba_s, addr_s} = ctl_s2;

  assign ckd = ck_s & ~ckn_s;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ckd_q <= 1'b0;
    end else begin
      ckd_q <= ckd;
    end
  end

  // clock pair ignored in self refresh
  assign ck_rise = ckd & ~ckd_q & (pwr_state_q != PWR_SELF_REF);
  assign ck_fall = ~ckd & ckd_q & (pwr_state_q != PWR_SELF_REF);

  //////////////////////////////////////////////////////////////////////////
  // Command decode
  logic running, cmd_ok;
  logic [ADDR_PINS-1:0] col;

  // commands only reach the decoder while running
  assign running = (pwr_state_q == PWR_RUN) && cke_s;
  // rank select is part of the code
  assign cmd_ok  = ck_rise && running && !cs_n_s;
  // column skips the auto precharge bit
  assign col = {1'b0, addr_s[ADDR_PINS-1:A10_POS+1], addr_s[A10_POS-1:0]};

  //////////////////////////////////////////////////////////////////////////
  // Power state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwr_state_q <= PWR_RUN;
    end else begin
      unique case (pwr_state_q)
        PWR_RUN: begin
          // entry sampled on a clock edge
          if (ck_rise && !cke_s) begin
            if (!cs_n_s && cmd_s == CMD_REFRESH && bank_open_q == '0) begin
              pwr_state_q <= PWR_SELF_REF;
            end else if (bank_open_q == '0) begin
              pwr_state_q <= PWR_PD_PRE;
            end else begin
              pwr_state_q <= PWR_PD_ACT;
            end
          end
        end
        PWR_PD_PRE, PWR_PD_ACT: begin
          // power-down exit waits for a clock edge
          if (ck_rise && cke_s) begin
            pwr_state_q <= PWR_RUN;
          end
        end
        PWR_SELF_REF: begin
          if (cke_s) begin
            pwr_state_q <= PWR_RUN;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Banks, rows and mode registers
  logic [ADDR_PINS-1:0] row_q [BANKS];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bank_open_q <= '0;
      last_row_q  <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_q[b] <= '0;
      end
    end else if (cmd_ok) begin
      case (cmd_s)
        CMD_ACT: begin
          // row opened in the chosen bank
          bank_open_q[ba_s] <= 1'b1;
          row_q[ba_s]       <= addr_s & ROW_MASK;
          last_row_q        <= addr_s & ROW_MASK;
        end
        CMD_PRE: begin
          if (addr_s[A10_POS]) begin
            bank_open_q <= '0;
          end else begin
            bank_open_q[ba_s] <= 1'b0;
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (addr_s[A10_POS]) begin
            bank_open_q[ba_s] <= 1'b0;
            last_row_q        <= row_q[ba_s];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_reg_q     <= MODE_RST;
      ext_mode_reg_q <= MODE_RST;
    end else if (cmd_ok && cmd_s == CMD_LMR) begin
      if (ba_s == BA_MODE) begin
        mode_reg_q <= addr_s;
      end else if (ba_s == BA_EXT_MODE) begin
        ext_mode_reg_q <= addr_s;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage port
  mem_port_if #(.AW(AW), .DW(2*DQ_W)) mp ();

  lane_mem #(.AW(AW), .DW(2*DQ_W)) u_mem (
    .clk_sys (clk_sys),
    .mp      (mp.mem)
  );

  logic                   wr_busy_q, wr_go;
  logic [AW-1:0]          wr_addr_q;
  logic [LANES-1:0]       lane_done;
  logic [2*DQ_W-1:0]      wr_word;
  logic [2*LANES-1:0]     wr_be;
  logic                   rd_cmd;

  assign rd_cmd = cmd_ok && cmd_s == CMD_READ;
  assign wr_go  = wr_busy_q && (&lane_done);
  assign mp.re   = rd_cmd;
  assign mp.we   = wr_go;
  assign mp.addr = wr_go ? wr_addr_q : {ba_s, col[COL_W-1:0]};
  assign mp.wdata = wr_word;
  assign mp.be    = wr_be;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_busy_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (cmd_ok && cmd_s == CMD_WRITE) begin
      wr_busy_q <= 1'b1;
      wr_addr_q <= {ba_s, col[COL_W-1:0]};
    end else if (wr_go || (cmd_ok && cmd_s == CMD_BST)) begin
      wr_busy_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write lanes: each strobe captures its own byte and mask
  logic wr_start;
  assign wr_start = cmd_ok && cmd_s == CMD_WRITE;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [7:0] b0_q, b1_q;
    logic       m0_q, m1_q, done_q, rise, fall;
    // lane strobe edges from the controller
    assign rise = dqs_s2[i] & ~dqs_s3[i] & wr_busy_q & running;
    assign fall = ~dqs_s2[i] & dqs_s3[i] & wr_busy_q & running;

    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        b0_q   <= '0;
        b1_q   <= '0;
        m0_q   <= 1'b1;
        m1_q   <= 1'b1;
        done_q <= 1'b0;
      end else begin
        if (rise) begin
          b0_q <= dq_s2[8*i +: 8];
          m0_q <= dm_s2[i];
        end
        if (fall) begin
          b1_q   <= dq_s2[8*i +: 8];
          m1_q   <= dm_s2[i];
          done_q <= 1'b1;
        end else if (wr_start || wr_go) begin
          done_q <= 1'b0;
        end
      end
    end

    assign lane_done[i]              = done_q;
    assign wr_word[8*i +: 8]         = b0_q;
    assign wr_word[DQ_W + 8*i +: 8]  = b1_q;
    assign wr_be[i]                  = ~m0_q;
    assign wr_be[LANES + i]          = ~m1_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Read return, edge aligned on the pair crossings
  rd_state_t rd_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_q <= RD_IDLE;
    end else if (!cke_s) begin
      rd_q <= RD_IDLE;
    end else begin
      unique case (rd_q)
        RD_IDLE:   if (rd_cmd) rd_q <= RD_WAIT;
        RD_WAIT:   if (ck_rise) rd_q <= RD_FIRST;
        RD_FIRST:  if (ck_fall) rd_q <= RD_SECOND;
        RD_SECOND: if (ck_rise) rd_q <= rd_cmd ? RD_WAIT : RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dq_o   <= '0;
      dq_oe  <= 1'b0;
      dqs_o  <= '0;
      dqs_oe <= '0;
    end else if (!cke_s) begin
      dq_oe  <= 1'b0;
      dqs_oe <= '0;
    end else if (rd_q == RD_WAIT && ck_rise) begin
      dq_o   <= mp.rdata[DQ_W-1:0];
      dqs_o  <= STROBE_HI;
      dq_oe  <= 1'b1;
      dqs_oe <= STROBE_HI;
    end else if (rd_q == RD_FIRST && ck_fall) begin
      // second word on the falling crossing
      dq_o  <= mp.rdata[2*DQ_W-1:DQ_W];
      dqs_o <= '0;
    end else if (rd_q == RD_SECOND && ck_rise) begin
      // release the strobe after the burst
      dq_oe  <= 1'b0;
      dqs_oe <= '0;
    end
  end

endmodule // ddr_module_cmd

`default_nettype wire

// file: tb/ddr_cmd_sva.sv
/*
 * Port checker for the module-side command block.
 * Assumes the bind below reaches every instance of the block.
 */
`timescale 1ns/1ps
`default_nettype none

module ddr_cmd_sva
  import ddr_cmd_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             rstn,
  input wire logic             rank_clock_enable,
  input wire logic [DQ_W-1:0]  dq_o,
  input wire logic             dq_oe,
  input wire logic [LANES-1:0] dqs_o,
  input wire logic [LANES-1:0] dqs_oe,
  input wire pwr_state_t       pwr_state_q,
  input wire logic [BANKS-1:0] bank_open_q,
  input wire logic [12:0]      mode_reg_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  oe_lanes_a: assert property (dqs_oe == {LANES{dq_oe}})
    else $error("strobe enables differ from data enable");
  rd_first_a: assert property ($rose(dq_oe) |-> dqs_o == STROBE_HI)
    else $error("read burst did not open with strobes high");
  rd_edge_a: assert property (
    dq_oe && $past(dq_oe) && $changed(dq_o) |-> $changed(dqs_o))
    else $error("read data moved without a strobe edge");
  cke_drv_a: assert property (!rank_clock_enable [*4] |-> !dq_oe)
    else $error("drivers on with clock enable low");
  pd_kind_a: assert property (pwr_state_q == PWR_PD_ACT |-> bank_open_q != 4'h0)
    else $error("active power-down with no open row");
  pre_idle_a: assert property (
    pwr_state_q inside {PWR_PD_PRE, PWR_SELF_REF} |-> bank_open_q == 4'h0)
    else $error("idle power state with an open row");
  pd_entry_a: assert property (
    $past(pwr_state_q) == PWR_RUN && pwr_state_q != PWR_RUN |-> !$past(rank_clock_enable, 3))
    else $error("power state left run without clock enable low");
  sref_exit_a: assert property (
    pwr_state_q == PWR_SELF_REF && rank_clock_enable |-> ##[1:4] pwr_state_q == PWR_RUN)
    else $error("self refresh not left on clock enable");
  sref_hold_a: assert property (
    !rank_clock_enable [*3] ##0 pwr_state_q == PWR_SELF_REF |=> pwr_state_q == PWR_SELF_REF)
    else $error("self refresh left with clock enable low");
  pd_quiet_a: assert property (
    pwr_state_q != PWR_RUN && $past(pwr_state_q) != PWR_RUN
      |-> $stable(bank_open_q) && $stable(mode_reg_q))
    else $error("state changed while powered down");

  cover property (pwr_state_q == PWR_SELF_REF);
  cover property (pwr_state_q == PWR_PD_ACT);
  cover property ($rose(dq_oe));
endmodule // ddr_cmd_sva

bind ddr_module_cmd ddr_cmd_sva u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .rank_clock_enable(rank_clock_enable),
  .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe),
  .pwr_state_q(pwr_state_q), .bank_open_q(bank_open_q), .mode_reg_q(mode_reg_q)
);

`default_nettype wire

// file: tb/ctl_model.sv
/*
 * Memory controller model: one memory clock period per command, write bursts.
 * Assumes a bench that resolves the shared data and strobe lines.
 */
`timescale 1ns/1ps
`default_nettype none

module ctl_model
  import ddr_cmd_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic [DQ_W-1:0]      dq_o,
  input  wire logic                 dq_oe,
  input  wire logic [LANES-1:0]     dqs_o,
  output logic                      ck,
  output logic                      ck_n,
  output logic                      rank_clock_enable,
  output logic                      rank_select_n,
  output logic [2:0]                cmd,
  output logic [1:0]                ba,
  output logic [ADDR_PINS-1:0]      addr,
  output logic [LANES-1:0]          dm,
  output logic [DQ_W-1:0]           dq_c,
  output logic [LANES-1:0]          dqs_c
);
  logic [DQ_W-1:0]  rd_lo, rd_hi;
  logic [LANES-1:0] st_r, st_f;
  logic             oe_r;

  initial begin
    {ck, ck_n, rank_clock_enable, rank_select_n} = 4'h7;
    cmd = CMD_NOP;
    ba = 2'h0;
    addr = 13'h0000;
    dm = 8'hff;
    dq_c = 64'h0000_0000_0000_0000;
    dqs_c = 8'h00;
  end

  task automatic cyc(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                     input logic s_n, input logic ce);
    @(negedge clk_sys);
    cmd = c;
    ba = b;
    addr = a;
    rank_select_n = s_n;
    rank_clock_enable = ce;
    dm = 8'hff;
    ck = 1'b1;
    ck_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd_lo = dq_o;
    st_r = dqs_o;
    oe_r = dq_oe;
    @(negedge clk_sys);
    ck = 1'b0;
    ck_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd_hi = dq_o;
    st_f = dqs_o;
  endtask

  task automatic wr(input logic [DQ_W-1:0] lo, hi, input logic [LANES-1:0] m0, m1);
    @(negedge clk_sys);
    dq_c = lo;
    dm = m0;
    repeat (4) @(negedge clk_sys);
    dqs_c = 8'hff;
    repeat (4) @(negedge clk_sys);
    dq_c = hi;
    dm = m1;
    repeat (4) @(negedge clk_sys);
    dqs_c = 8'h00;
    repeat (4) @(negedge clk_sys);
    // Released bus shows the inverse, not the last word
    dq_c = ~hi;
    dm = ~m1;
  endtask

  task automatic wake();
    @(negedge clk_sys);
    rank_clock_enable = 1'b1;
    repeat (5) @(negedge clk_sys);
  endtask
endmodule // ctl_model

`default_nettype wire

// file: tb/tb_ddr_module_command_interface.sv
/*
 * Bench for the module-side command block, with the controller model.
 * Assumes the checker binds itself to the block.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_ddr_module_command_interface
  import ddr_cmd_pkg::*;
;
  localparam logic [DQ_W-1:0] W1L = 64'h0123_4567_89ab_cdef;
  localparam logic [DQ_W-1:0] W1H = 64'hfedc_ba98_7654_3210;
  localparam logic [DQ_W-1:0] W2L = 64'h5a5a_1111_2222_3333;
  localparam logic [DQ_W-1:0] W2H = 64'h4444_5555_6666_a5a5;
  logic                 clk_sys, rstn, ck, ck_n, rank_clock_enable, rank_select_n, dq_oe;
  logic [2:0]           cmd;
  logic [1:0]           ba;
  logic [ADDR_PINS-1:0] addr, last_row_q, mode_reg_q, ext_mode_reg_q;
  logic [LANES-1:0]     dm, dqs_c, dqs_i, dqs_o, dqs_oe;
  logic [DQ_W-1:0]      dq_c, dq_i, dq_o;
  logic [BANKS-1:0]     bank_open_q;
  pwr_state_t           pwr_state_q;
  int                   errors, n_checks, cycles;

  // Shared lines: whoever has its enable up drives
  assign dq_i  = dq_oe ? dq_o : dq_c;
  assign dqs_i = (dqs_oe & dqs_o) | (~dqs_oe & dqs_c);

  ddr_module_cmd u_dut (
    .clk_sys, .rstn, .ck, .ck_n, .rank_clock_enable, .rank_select_n,
    .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba, .addr, .dm, .dq_i, .dq_o,
    .dq_oe, .dqs_i, .dqs_o, .dqs_oe, .pwr_state_q, .bank_open_q, .last_row_q,
    .mode_reg_q, .ext_mode_reg_q
  );

  ctl_model u_ctl (
    .clk_sys, .dq_o, .dq_oe, .dqs_o, .ck, .ck_n, .rank_clock_enable, .rank_select_n,
    .cmd, .ba, .addr, .dm, .dq_c, .dqs_c
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DQ_W-1:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] o, n, input logic [7:0] m);
    merge = n;
    for (int i = 0; i < LANES; i++) if (m[i]) merge[8*i +: 8] = o[8*i +: 8];
  endfunction

  // Run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    rstn = 1'b0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    chk("pwr", 64'(PWR_RUN), 64'(pwr_state_q));
    u_ctl.cyc(CMD_LMR, BA_MODE, 13'h0032, 1'b0, 1'b1);
    u_ctl.cyc(CMD_LMR, BA_EXT_MODE, 13'h1001, 1'b0, 1'b1);
    chk("mode", 64'h0032, 64'(mode_reg_q));
    chk("ext", 64'h1001, 64'(ext_mode_reg_q));
    u_ctl.cyc(CMD_LMR, 2'h2, 13'h0fff, 1'b0, 1'b1);
    chk("mode", 64'h0032, 64'(mode_reg_q));
    chk("ext", 64'h1001, 64'(ext_mode_reg_q));
    u_ctl.cyc(CMD_ACT, 2'h2, 13'h1abc, 1'b1, 1'b1);
    chk("banks", 64'h0, 64'(bank_open_q));
    u_ctl.cyc(CMD_ACT, 2'h2, 13'h1abc, 1'b0, 1'b1);
    chk("banks", 64'h4, 64'(bank_open_q));
    chk("row", 64'h1abc, 64'(last_row_q));
    u_ctl.cyc(CMD_WRITE, 2'h2, 13'h0001, 1'b0, 1'b1);
    u_ctl.wr(W1L, W1H, 8'h00, 8'h00);
    u_ctl.cyc(CMD_WRITE, 2'h2, 13'h0001, 1'b0, 1'b1);
    u_ctl.wr(W2L, W2H, 8'h0f, 8'hf0);
    u_ctl.cyc(CMD_READ, 2'h2, 13'h0001, 1'b0, 1'b1);
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk("rd_lo", merge(W1L, W2L, 8'h0f), u_ctl.rd_lo);
    chk("rd_hi", merge(W1H, W2H, 8'hf0), u_ctl.rd_hi);
    chk("st_rise", 64'hff, 64'(u_ctl.st_r));
    chk("st_fall", 64'h0, 64'(u_ctl.st_f));
    chk("oe_rd", 64'h1, 64'(u_ctl.oe_r));
    u_ctl.cyc(CMD_READ, 2'h2, 13'h0401, 1'b0, 1'b1);
    chk("banks", 64'h0, 64'(bank_open_q));
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk("rd_ap", merge(W1L, W2L, 8'h0f), u_ctl.rd_lo);
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk("oe_idle", 64'h0, 64'(u_ctl.oe_r));
    u_ctl.cyc(CMD_ACT, 2'h0, 13'h0005, 1'b0, 1'b1);
    u_ctl.cyc(CMD_ACT, 2'h1, 13'h0006, 1'b0, 1'b1);
    u_ctl.cyc(CMD_PRE, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk("banks", 64'h2, 64'(bank_open_q));
    u_ctl.cyc(CMD_ACT, 2'h3, 13'h0007, 1'b0, 1'b1);
    chk("row", 64'h0007, 64'(last_row_q));
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
    chk("pwr", 64'(PWR_PD_ACT), 64'(pwr_state_q));
    u_ctl.cyc(CMD_PRE, 2'h0, 13'h0400, 1'b0, 1'b0);
    chk("banks", 64'ha, 64'(bank_open_q));
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk("pwr", 64'(PWR_RUN), 64'(pwr_state_q));
    u_ctl.cyc(CMD_PRE, 2'h1, 13'h0400, 1'b0, 1'b1);
    chk("banks", 64'h0, 64'(bank_open_q));
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
    chk("pwr", 64'(PWR_PD_PRE), 64'(pwr_state_q));
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    u_ctl.cyc(CMD_REFRESH, 2'h0, 13'h0000, 1'b0, 1'b0);
    chk("pwr", 64'(PWR_SELF_REF), 64'(pwr_state_q));
    u_ctl.cyc(CMD_ACT, 2'h1, 13'h0009, 1'b0, 1'b0);
    chk("pwr", 64'(PWR_SELF_REF), 64'(pwr_state_q));
    u_ctl.wake();
    chk("pwr", 64'(PWR_RUN), 64'(pwr_state_q));
    chk("banks", 64'h0, 64'(bank_open_q));
    // Burst stop disarms a write, so its strobes must leave the word alone
    u_ctl.cyc(CMD_WRITE, 2'h2, 13'h0001, 1'b0, 1'b1);
    u_ctl.cyc(CMD_BST, 2'h0, 13'h0000, 1'b0, 1'b1);
    u_ctl.wr(W1H, W1L, 8'h00, 8'h00);
    u_ctl.cyc(CMD_READ, 2'h2, 13'h0001, 1'b0, 1'b1);
    u_ctl.cyc(CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk("rd_bst", merge(W1L, W2L, 8'h0f), u_ctl.rd_lo);
    wrap_up();
  end
endmodule // tb_ddr_module_command_interface

`default_nettype wire
